// >>> src/crfs_map.svh
// Purpose: register offsets, field positions and thresholds of the receive flag block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef CRFS_MAP_SVH
`define CRFS_MAP_SVH
`define CRFS_FLAG_OFS      8'h04
`define CRFS_MASK_OFS      8'h05
`define CRFS_CTRL_OFS      8'h08
`define CRFS_STAT_OFS      8'h0C
`define CRFS_FLAG_ADDR     8'h10
`define CRFS_MASK_ADDR     8'h14
`define CRFS_CTRL_ADDR     8'h20
`define CRFS_STAT_ADDR     8'h30
`define CRFS_BIT_WAKE      7
`define CRFS_BIT_CSC       6
`define CRFS_RX_HI         5
`define CRFS_RX_LO         4
`define CRFS_TX_HI         3
`define CRFS_TX_LO         2
`define CRFS_BIT_OVR       1
`define CRFS_BIT_RXF       0
`define CRFS_CTL_INIT_REQUEST    0
`define CRFS_CTL_WAKEEN    1
`define CRFS_CTL_SLEEP     2
`define CRFS_FLAG_RST      8'h00
`define CRFS_MASK_RST      8'h00
`define CRFS_CTRL_RST      8'h00
`define CRFS_WARN_LIM      9'h060
`define CRFS_PASS_LIM      9'h07F
`define CRFS_BOFF_LIM      9'h0FF
`define CRFS_ST_OK         2'h0
`define CRFS_ST_WARN       2'h1
`define CRFS_ST_PASS       2'h2
`define CRFS_ST_BOFF       2'h3
`endif

// >>> src/crfs_pkg.sv
// Purpose: shared types of the receive flag block
// Assumes: map header holds all register numbers; mode codes are set here
// Notes:   types only
package crfs_pkg;
  typedef struct packed {
    logic [8:0] tx_count;
    logic [8:0] rx_count;
    logic       overrun;
    logic       msg_ok;
    logic       bus_activity;
  } crfs_engine_t;
  typedef struct packed {
    logic [1:0] rx_code;
    logic [1:0] tx_code;
  } crfs_codes_t;
  typedef enum logic [1:0] {
    CRFS_RUN  = 2'h1,
    CRFS_INIT = 2'h2
  } crfs_mode_t;
endpackage : crfs_pkg

// >>> src/crfs_state_enc.sv
// Purpose: encode receiver and transmitter state codes from error counts
// Assumes: counts are 9 bits wide, sampled on clk
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "crfs_map.svh"
module crfs_state_enc (
  input  wire logic [8:0]          tx_count,
  input  wire logic [8:0]          rx_count,
  output var crfs_pkg::crfs_codes_t codes
);
  // shared threshold decode
  function automatic logic [1:0] lvl(input logic [8:0] c);
    if (c <= `CRFS_WARN_LIM) lvl = `CRFS_ST_OK;
    else if (c <= `CRFS_PASS_LIM) lvl = `CRFS_ST_WARN;
    else if (c <= `CRFS_BOFF_LIM) lvl = `CRFS_ST_PASS;
    else lvl = `CRFS_ST_BOFF;
  endfunction : lvl
  always_comb begin
    codes.tx_code = lvl(tx_count);
    // bus-off forces receiver bus-off; the skip back to normal on leaving is done by the caller
    if (codes.tx_code == `CRFS_ST_BOFF) begin
      codes.rx_code = `CRFS_ST_BOFF;
    end else if (lvl(rx_count) == `CRFS_ST_BOFF) begin
      codes.rx_code = `CRFS_ST_PASS;
    end else begin
      codes.rx_code = lvl(rx_count);
    end
  end
endmodule : crfs_state_enc
`default_nettype wire

// >>> src/crfs_sync.sv
// Purpose: two-flop synchroniser for a level from outside the clock
// Assumes: single clock
// Notes:   first flop read only by second
`timescale 1ns/1ps
`default_nettype none
module crfs_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'h0;
      dout   <= 1'h0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : crfs_sync
`default_nettype wire

// >>> src/crfs_flags.sv
// Purpose: receive flag register, state codes, mask and interrupt of a can controller
// Assumes: classic wishbone slave, 250 MHz clk, engine inputs on clk
// Notes:   one registered ack per access; unmapped reads return zero
// Behaviour
// - write one clears flag, set wins
// - init mode holds flags in reset
// - state codes survive init mode
// - zero writes ignored, codes read-only
// - bus activity in sleep sets wake
// - state code change sets status flag
// - codes frozen while status flag pending
// - receiver code from receive count
// - transmitter code from transmit count
// - bus-off forces receiver bus-off
// - overrun strobe sets overrun flag
// - good message sets pending flag
// - no shift while pending flag set
// - irq only when flag enabled
// - ack only after init entered
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crfs_map.svh"
module crfs_flags #(
  parameter int DAT_W = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [DAT_W/8-1:0] wb_sel_i,
  input  wire logic [DAT_W-1:0]   wb_dat_i,
  output logic [DAT_W-1:0]        wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [8:0]  tx_error_count,
  input  wire logic [8:0]  rx_error_count,
  input  wire logic        overrun_strobe,
  input  wire logic        msg_ok_strobe,
  input  wire logic        rx_fifo_avail,
  input  wire logic        can_rx_pin,
  output logic             shift_front_rx_buffer,
  output logic             init_ack,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]           flags;
    crfs_pkg::crfs_codes_t codes;
    logic [7:0]           mask;
    logic [7:0]           ctrl;
    crfs_pkg::crfs_mode_t mode;
    logic                 rx_prev;
    logic                 shift;
    logic                 irq;
    logic                 ack;
    logic [DAT_W-1:0]     rdat;
  } crfs_state_t;

  // the read path puts one byte in the low lane and zero-fills the rest
  if (DAT_W < 16 || (DAT_W % 8) != 0) begin : g_bad_width
    $error("data width must be a multiple of 8 and at least 16");
  end

  crfs_state_t s_q, s_d;
  crfs_pkg::crfs_engine_t eng;
  crfs_pkg::crfs_codes_t  live;
  logic                   rx_sync;

  // pin activity comes from another domain
  crfs_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (can_rx_pin),
    .dout  (rx_sync)
  );

  crfs_state_enc u_enc (
    .tx_count (eng.tx_count),
    .rx_count (eng.rx_count),
    .codes    (live)
  );

  always_comb begin
    eng.tx_count     = tx_error_count;
    eng.rx_count     = rx_error_count;
    eng.overrun      = overrun_strobe;
    eng.msg_ok       = msg_ok_strobe;
    eng.bus_activity = s_q.rx_prev && !rx_sync;
  end

  logic in_init;
  logic wr, rd;
  logic [7:0] wdat;
  logic [7:0] clr;
  logic [7:0] set;
  logic       code_chg;
  logic [7:0] flag_nx;
  logic [7:0] rbyte;
  crfs_pkg::crfs_codes_t cap;

  // register image: stored flags with the held state codes spliced into 5:2
  function automatic logic [7:0] flag_view(input logic [7:0] f,
                                           input crfs_pkg::crfs_codes_t c);
    flag_view = {f[`CRFS_BIT_WAKE], f[`CRFS_BIT_CSC], c.rx_code, c.tx_code,
                 f[`CRFS_BIT_OVR], f[`CRFS_BIT_RXF]};
  endfunction : flag_view

  function automatic logic flag_hit(input logic [7:0] a);
    flag_hit = (a == `CRFS_FLAG_ADDR);
  endfunction : flag_hit

  // one next-value slice per flag bit; the code bits are overwritten later
  for (genvar gi = 0; gi < $bits(flag_nx); gi++) begin : g_flag
    assign flag_nx[gi] = set[gi] | (s_q.flags[gi] & ~clr[gi]);
  end

  always_comb begin
    s_d      = s_q;
    wr       = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
    rd       = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
    wdat     = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
    in_init  = s_q.ctrl[`CRFS_CTL_INIT_REQUEST] && (s_q.mode == crfs_pkg::CRFS_INIT);
    clr      = 8'h00;
    set      = 8'h00;
    rbyte    = 8'h00;
    cap      = live;
    if (s_q.codes.tx_code == `CRFS_ST_BOFF && live.tx_code != `CRFS_ST_BOFF) begin
      // leaving bus-off skips the receiver straight back to normal
      cap.rx_code = `CRFS_ST_OK;
    end
    code_chg = (cap != s_q.codes);
    s_d.rx_prev = rx_sync;

    // ack follows request, then drops for one cycle
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;

    // init handshake: ack only when mode really entered
    if (s_q.ctrl[`CRFS_CTL_INIT_REQUEST]) begin
      s_d.mode = crfs_pkg::CRFS_INIT;
    end else begin
      s_d.mode = crfs_pkg::CRFS_RUN;
    end

    if (wr && flag_hit(wb_adr_i) && !in_init) begin
      // zero bits leave flags alone; codes are read-only
      clr = wdat;
      clr[`CRFS_RX_HI:`CRFS_TX_LO] = 4'h0;
    end
    if (wr && wb_adr_i == `CRFS_MASK_ADDR && !in_init) begin
      s_d.mask = wdat;
    end
    if (wr && wb_adr_i == `CRFS_CTRL_ADDR) begin
      s_d.ctrl = wdat;
    end

    set[`CRFS_BIT_WAKE] = eng.bus_activity && s_q.ctrl[`CRFS_CTL_SLEEP]
                          && s_q.ctrl[`CRFS_CTL_WAKEEN];
    set[`CRFS_BIT_CSC]  = code_chg && !s_q.flags[`CRFS_BIT_CSC];
    set[`CRFS_BIT_OVR]  = eng.overrun;
    set[`CRFS_BIT_RXF]  = eng.msg_ok;

    // clear applies first so a same-cycle event is kept
    s_d.flags = flag_nx;
    s_d.flags[`CRFS_RX_HI:`CRFS_TX_LO] = 4'h0;

    // codes update only while no status change is pending
    if (!s_q.flags[`CRFS_BIT_CSC]) begin
      s_d.codes = cap;
    end

    if (in_init) begin
      s_d.flags = `CRFS_FLAG_RST;
      s_d.mask  = `CRFS_MASK_RST;
    end

    // one-cycle shift request only while buffer released
    s_d.shift = rx_fifo_avail && !s_q.flags[`CRFS_BIT_RXF] && !s_q.shift
                && !in_init;

    s_d.irq = |(s_q.flags & s_q.mask);

    if (rd) begin
      case (wb_adr_i)
        `CRFS_FLAG_ADDR: rbyte = flag_view(s_q.flags, s_q.codes);
        `CRFS_MASK_ADDR: rbyte = s_q.mask;
        `CRFS_CTRL_ADDR: rbyte = s_q.ctrl;
        `CRFS_STAT_ADDR: rbyte = {7'h00, in_init};
        default:         rbyte = 8'h00;
      endcase
    end
    s_d.rdat = {{(DAT_W - 8){1'b0}}, rbyte};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{flags: `CRFS_FLAG_RST, codes: '{`CRFS_ST_OK, `CRFS_ST_OK},
               mask: `CRFS_MASK_RST, ctrl: `CRFS_CTRL_RST, mode: crfs_pkg::CRFS_RUN,
               rx_prev: 1'h0, shift: 1'h0, irq: 1'h0, ack: 1'h0, rdat: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    wb_dat_o              = s_q.rdat;
    wb_ack_o              = s_q.ack;
    shift_front_rx_buffer = s_q.shift;
    init_ack              = (s_q.mode == crfs_pkg::CRFS_INIT);
    irq                   = s_q.irq;
  end

  chk_codes_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.flags[`CRFS_BIT_CSC] |=> $stable(s_q.codes))
    else $error("state codes moved while status flag pending");
  chk_rxf_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.flags[`CRFS_BIT_RXF] |=> !s_q.shift)
    else $error("shift while pending flag set");
  chk_ovr_set: assert property (@(posedge clk) disable iff (!rst_n)
    (overrun_strobe && !in_init) |=> s_q.flags[`CRFS_BIT_OVR])
    else $error("overrun strobe lost");
  chk_rxf_set: assert property (@(posedge clk) disable iff (!rst_n)
    (msg_ok_strobe && !in_init) |=> s_q.flags[`CRFS_BIT_RXF])
    else $error("message strobe lost");
  chk_init_hold: assert property (@(posedge clk) disable iff (!rst_n)
    in_init |=> s_q.flags == `CRFS_FLAG_RST)
    else $error("flags not held in init");
  chk_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ((s_q.flags & s_q.mask) == 8'h00) |=> !irq)
    else $error("irq without enabled flag");
  chk_csc_on_change: assert property (@(posedge clk) disable iff (!rst_n)
    (code_chg && !s_q.flags[`CRFS_BIT_CSC] && !in_init) |=> s_q.flags[`CRFS_BIT_CSC])
    else $error("status change not flagged");
  chk_zero_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && wb_adr_i == `CRFS_FLAG_ADDR && wdat == 8'h00 && s_q.flags[`CRFS_BIT_OVR])
    |=> s_q.flags[`CRFS_BIT_OVR] || $past(in_init))
    else $error("zero write cleared a flag");
  chk_ack_init: assert property (@(posedge clk) disable iff (!rst_n)
    init_ack |-> $past(s_q.ctrl[`CRFS_CTL_INIT_REQUEST]))
    else $error("init ack without request");

  // bus and event steps shared by the properties below
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !s_q.ack;
  endsequence : s_bus_take

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence : s_ack_pulse

  sequence s_flag_read;
    rd && flag_hit(wb_adr_i);
  endsequence : s_flag_read

  sequence s_wake_event;
    eng.bus_activity && s_q.ctrl[`CRFS_CTL_SLEEP] && s_q.ctrl[`CRFS_CTL_WAKEEN] && !in_init;
  endsequence : s_wake_event

  sequence s_ovr_clear;
    wr && flag_hit(wb_adr_i) && wdat[`CRFS_BIT_OVR] && !in_init;
  endsequence : s_ovr_clear

  chk_ack_timing: assert property (@(posedge clk) disable iff (!rst_n)
    s_bus_take |=> s_ack_pulse)
    else $error("ack not a single pulse after request");

  chk_flag_image: assert property (@(posedge clk) disable iff (!rst_n)
    s_flag_read |=> wb_dat_o[7:0] == flag_view($past(s_q.flags), $past(s_q.codes)))
    else $error("flag read returned wrong image");

  chk_rd_zero_hi: assert property (@(posedge clk) disable iff (!rst_n)
    s_bus_take ##0 !wb_we_i |=> wb_dat_o[DAT_W-1:8] == '0)
    else $error("upper read lanes not zero");

  chk_wake_set: assert property (@(posedge clk) disable iff (!rst_n)
    s_wake_event |=> s_q.flags[`CRFS_BIT_WAKE])
    else $error("wake activity lost");

  chk_wake_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_q.flags[`CRFS_BIT_WAKE] && !(eng.bus_activity && s_q.ctrl[`CRFS_CTL_SLEEP]
     && s_q.ctrl[`CRFS_CTL_WAKEEN])) |=> !s_q.flags[`CRFS_BIT_WAKE])
    else $error("wake flag set without event");

  chk_ovr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_ovr_clear ##0 !overrun_strobe |=> !s_q.flags[`CRFS_BIT_OVR])
    else $error("write of one did not clear overrun");

  chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    s_ovr_clear ##0 overrun_strobe |=> s_q.flags[`CRFS_BIT_OVR])
    else $error("clear beat a same-cycle overrun");

  chk_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (|(s_q.flags & s_q.mask)) |=> irq)
    else $error("enabled flag without irq");

  chk_rxf_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.flags[`CRFS_BIT_RXF] && s_q.mask[`CRFS_BIT_RXF]) |=> irq)
    else $error("receive interrupt missing");

  chk_csc_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.flags[`CRFS_BIT_CSC] && s_q.mask[`CRFS_BIT_CSC]) |=> irq)
    else $error("status change interrupt missing");

  chk_mask_init: assert property (@(posedge clk) disable iff (!rst_n)
    in_init |=> s_q.mask == `CRFS_MASK_RST)
    else $error("mask not held in init");

  chk_codes_init: assert property (@(posedge clk) disable iff (!rst_n)
    (in_init && !s_q.flags[`CRFS_BIT_CSC]) |=> s_q.codes == $past(cap))
    else $error("state codes stopped in init");

  chk_no_code_bits: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.flags[`CRFS_RX_HI:`CRFS_TX_LO] == 4'h0)
    else $error("code bits written into flag store");

  chk_boff_both: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.codes.tx_code == `CRFS_ST_BOFF |-> s_q.codes.rx_code == `CRFS_ST_BOFF)
    else $error("receiver not bus-off with transmitter");

  chk_boff_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.codes.tx_code == `CRFS_ST_BOFF && live.tx_code != `CRFS_ST_BOFF
     && !s_q.flags[`CRFS_BIT_CSC]) |=> s_q.codes.rx_code == `CRFS_ST_OK)
    else $error("receiver did not skip to normal");

  chk_shift_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.shift |=> !s_q.shift)
    else $error("shift request longer than one cycle");

  chk_shift_rx: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_fifo_avail && !s_q.flags[`CRFS_BIT_RXF] && !s_q.shift && !in_init)
    |=> shift_front_rx_buffer)
    else $error("released buffer not refilled");

  chk_ack_mode: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.ctrl[`CRFS_CTL_INIT_REQUEST] |=> init_ack)
    else $error("init request not acknowledged");
endmodule : crfs_flags
`default_nettype wire

// >>> tb/crfs_flags_bench.sv
// Purpose: self-checking bench of the receive flag block
// Assumes: classic wishbone master, one clock, ack one cycle after the taking edge
// Notes:   engine counts and strobes are driven by the bench, no partner model
`timescale 1ns/1ps
`default_nettype none
`include "crfs_map.svh"
module crfs_flags_bench;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [8:0]  tx_n;
  logic [8:0]  rx_n;
  logic        ovr;
  logic        msg;
  logic        avail;
  logic        pin;
  logic        shift;
  logic        iack;
  logic        irq;
  int          n_mismatch;
  int          check_count;
  int          shifts;
  int          cycles;
  int          base;
  logic [8:0]  tx_tab [7] = '{9'h0C8, 9'h0C8, 9'h100, 9'h000, 9'h060, 9'h07F, 9'h064};
  logic [8:0]  rx_tab [7] = '{9'h000, 9'h078, 9'h078, 9'h000, 9'h080, 9'h061, 9'h000};
  logic [7:0]  fl_tab [7] = '{8'h48, 8'h58, 8'h7C, 8'h40, 8'h60, 8'h54, 8'h44};

  crfs_flags u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_error_count(tx_n), .rx_error_count(rx_n), .overrun_strobe(ovr), .msg_ok_strobe(msg),
    .rx_fifo_avail(avail), .can_rx_pin(pin), .shift_front_rx_buffer(shift),
    .init_ack(iack), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // overall run limit; a hung handshake already gives up after 50 cycles in wb
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (shift === 1'b1) shifts <= shifts + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk1("wb_ack", 1'b1, (n < 50));
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk8("read", e, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic pulse_ovr();
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_ovr

  task automatic wait_iack(input logic v);
    for (int i = 0; i < 20 && iack !== v; i++) @(posedge clk);
    chk1("init_ack", v, iack);
  endtask : wait_iack

  task automatic set_cnt(input logic [8:0] t, input logic [8:0] r);
    tx_n <= t;
    rx_n <= r;
    repeat (4) @(posedge clk);
  endtask : set_cnt

  initial begin
    {cyc, stb, we, adr, wdat, ovr, msg, avail} = '0;
    {tx_n, rx_n, n_mismatch, check_count, shifts, cycles} = '0;
    pin = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CRFS_FLAG_ADDR, 8'h00);
    rd(`CRFS_MASK_ADDR, 8'h00);
    rd(8'h3C, 8'h00);
    $display("test reset done");
    set_cnt(9'h064, 9'h000);
    rd(`CRFS_FLAG_ADDR, 8'h44);
    set_cnt(9'h0C8, 9'h000);
    rd(`CRFS_FLAG_ADDR, 8'h44);
    wr(`CRFS_FLAG_ADDR, 8'h40);
    rd(`CRFS_FLAG_ADDR, 8'h48);
    for (int i = 0; i < 7; i++) begin
      set_cnt(tx_tab[i], rx_tab[i]);
      rd(`CRFS_FLAG_ADDR, fl_tab[i]);
      wr(`CRFS_FLAG_ADDR, 8'h40);
      rd(`CRFS_FLAG_ADDR, fl_tab[i] & 8'hBF);
    end
    // leaving bus-off with a high receive count still reads normal first
    set_cnt(9'h100, 9'h078);
    wr(`CRFS_FLAG_ADDR, 8'h40);
    set_cnt(9'h000, 9'h078);
    rd(`CRFS_FLAG_ADDR, 8'h40);
    wr(`CRFS_FLAG_ADDR, 8'h40);
    rd(`CRFS_FLAG_ADDR, 8'h50);
    set_cnt(9'h064, 9'h000);
    wr(`CRFS_FLAG_ADDR, 8'h40);
    rd(`CRFS_FLAG_ADDR, 8'h44);
    wr(`CRFS_FLAG_ADDR, 8'h40);
    $display("test state codes done");
    pulse_ovr();
    rd(`CRFS_FLAG_ADDR, 8'h06);
    wr(`CRFS_CTRL_ADDR, 8'h01);
    wait_iack(1'b1);
    rd(`CRFS_FLAG_ADDR, 8'h04);
    wr(`CRFS_CTRL_ADDR, 8'h00);
    wait_iack(1'b0);
    pulse_ovr();
    wr(`CRFS_FLAG_ADDR, 8'h3C);
    rd(`CRFS_FLAG_ADDR, 8'h06);
    wr(`CRFS_MASK_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    chk1("irq", 1'b1, irq);
    wr(`CRFS_FLAG_ADDR, 8'h02);
    rd(`CRFS_FLAG_ADDR, 8'h04);
    chk1("irq", 1'b0, irq);
    $display("test init and overrun done");
    wr(`CRFS_MASK_ADDR, 8'h01);
    msg <= 1'b1;
    @(posedge clk);
    msg <= 1'b0;
    avail <= 1'b1;
    repeat (3) @(posedge clk);
    chk1("irq", 1'b1, irq);
    base = shifts;
    repeat (10) @(posedge clk);
    chk1("shift", 1'b0, (shifts != base));
    wr(`CRFS_FLAG_ADDR, 8'h01);
    repeat (6) @(posedge clk);
    chk1("shift", 1'b1, (shifts != base));
    chk1("irq", 1'b0, irq);
    avail <= 1'b0;
    $display("test receive done");
    // sleep without wake enable must leave the flag alone
    wr(`CRFS_CTRL_ADDR, 8'h04);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    pin <= 1'b1;
    rd(`CRFS_FLAG_ADDR, 8'h04);
    wr(`CRFS_CTRL_ADDR, 8'h06);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    pin <= 1'b1;
    rd(`CRFS_FLAG_ADDR, 8'h84);
    wr(`CRFS_FLAG_ADDR, 8'h80);
    rd(`CRFS_FLAG_ADDR, 8'h04);
    $display("test wake done");
    wrap_up();
  end
endmodule : crfs_flags_bench
`default_nettype wire
